// ===== rtl/ppsb_regs.svh
`ifndef PPSB_REGS_SVH
`define PPSB_REGS_SVH

// register offsets on the byte-wide register port
`define PPSB_ADDR_CFG_STATUS   8'h00
`define PPSB_ADDR_OP_STATUS    8'h01
`define PPSB_ADDR_CELL_BALANCE 8'h02

// configuration status fields
`define PPSB_CFG_UPPER_BIT     7
`define PPSB_CFG_LOWER_BIT     6
`define PPSB_CFG_WAKE_BIT      4

// operating status fields
`define PPSB_OP_XOT_BIT        5
`define PPSB_OP_IOT_BIT        4
`define PPSB_OP_LDF_BIT        3
`define PPSB_OP_DSC_BIT        2
`define PPSB_OP_DOC_BIT        1
`define PPSB_OP_COC_BIT        0
`define PPSB_OP_FLAG_COUNT     6
// flags that only the lower device implements
`define PPSB_LOWER_ONLY_MASK   6'h2F

// cell balance fields
`define PPSB_BAL_WAKE_REQ_BIT  6
`define PPSB_BAL_CELL7_BIT     7
`define PPSB_BAL_WRITE_MASK    8'hFE

// reset values
`define PPSB_BAL_RESET         8'h00
`define PPSB_RDATA_RESET       8'h00

`endif

// ===== rtl/ppsb_pkg.sv
package ppsb_pkg;

  typedef struct packed {
    logic [7:0] bal;
    logic [7:0] rdata;
    logic       fet_clr;
  } ppsb_core_state_type;

  typedef struct packed {
    logic flag;
  } ppsb_flag_state_type;

endpackage

// ===== rtl/ppsb_sticky_flag.sv
`timescale 1ns/1ns
module ppsb_sticky_flag (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // condition and clear
  input  wire logic cond,
  input  wire logic read_clr,
  // flag
  output logic      flag
);

  ppsb_pkg::ppsb_flag_state_type st_reg;
  ppsb_pkg::ppsb_flag_state_type st_next;

  // a live condition overrides the read clear, so a fault seen during the read is kept
  always_comb begin
    st_next      = st_reg;
    st_next.flag = cond | (st_reg.flag & ~read_clr);  // [RULE_17]
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag = st_reg.flag;

  property p_flag_set;
    @(posedge core_clk) disable iff (!rst_b) cond |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by condition");  // [RULE_17]

  property p_flag_clear;
    @(posedge core_clk) disable iff (!rst_b) (read_clr && !cond) |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");

  property p_flag_hold;
    @(posedge core_clk) disable iff (!rst_b) (flag && !read_clr) |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without read");

endmodule // ppsb_sticky_flag

// ===== rtl/ppsb_status_balance.sv
// What this block does
// RULE_01: config status bit 7 is a fixed read-only flag marking the upper device.
// RULE_02: config status bit 6 is a fixed read-only flag marking the lower device.
// RULE_03: config status bits 5 and 3 to 0 are reserved and read zero.
// RULE_04: config status bit 4 is wake pin level adjusted by wake polarity.
// RULE_05: op status bit 5 sets on external over-temperature, clears on read after.
// RULE_06: op status bit 4 sets on internal over-temperature, clears on read after.
// RULE_07: op status bit 3 sets on monitored fault with heavy load, read clears.
// RULE_08: op status bit 2 sets on discharge short, clears on read once removed.
// RULE_09: op status bit 1 sets on discharge overcurrent, clears on read afterwards.
// RULE_10: op status bit 0 sets on charge overcurrent, clears on read afterwards.
// RULE_11: balance bits 1 to 7 switch cell balancing on or off; bit 0 reserved.
// RULE_12: on the lower device balance bit 6 also drives the wake request output.
// RULE_13: balance bit 7 balances a seventh cell only on the upper device.
// RULE_14: software writes zero to reserved bits and ignores them on reads.
// RULE_15: forced sleep clears all balance bits and both switch drive bits.
// RULE_16: status bits unused on the upper device read zero there.
// RULE_17: a flag whose condition persists during a read stays set.
`timescale 1ns/1ns
`include "ppsb_regs.svh"
module ppsb_status_balance #(
  parameter bit IS_UPPER = 1'b0
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register port from the serial engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // wake pin
  input  wire logic       wake_pin_above,
  input  wire logic       wake_polarity,
  // fault conditions
  input  wire logic       ext_overtemp,
  input  wire logic       int_overtemp,
  input  wire logic       load_monitor,
  input  wire logic       load_heavy,
  input  wire logic       discharge_short,
  input  wire logic       discharge_overcurrent,
  input  wire logic       charge_overcurrent,
  // sleep
  input  wire logic       force_sleep,
  output logic            fet_drive_clear,
  // balance outputs
  output logic      [7:1] balance_cell,
  output logic            wake_request_output
);

  ppsb_pkg::ppsb_core_state_type st_reg;
  ppsb_pkg::ppsb_core_state_type st_next;

  logic [`PPSB_OP_FLAG_COUNT-1:0] cond_raw;
  logic [`PPSB_OP_FLAG_COUNT-1:0] cond_eff;
  logic [`PPSB_OP_FLAG_COUNT-1:0] flags;
  logic                           op_read;
  logic                           wake_pin_status;
  logic [7:0]                     cfg_value;

  assign op_read         = reg_rd && (reg_addr == `PPSB_ADDR_OP_STATUS);
  assign wake_pin_status = ~(wake_pin_above ^ wake_polarity);  // [RULE_04]

  always_comb begin
    cond_raw                    = '0;
    cond_raw[`PPSB_OP_XOT_BIT]  = ext_overtemp;           // [RULE_05]
    cond_raw[`PPSB_OP_IOT_BIT]  = int_overtemp;           // [RULE_06]
    // the flag is set by a fault only while the load is monitored and heavy
    cond_raw[`PPSB_OP_LDF_BIT]  = load_monitor && load_heavy
                                  && (discharge_short || discharge_overcurrent);  // [RULE_07]
    cond_raw[`PPSB_OP_DSC_BIT]  = discharge_short;        // [RULE_08]
    cond_raw[`PPSB_OP_DOC_BIT]  = discharge_overcurrent;  // [RULE_09]
    cond_raw[`PPSB_OP_COC_BIT]  = charge_overcurrent;     // [RULE_10]
  end

  // lower-only flags are held off on the upper device so they read zero
  assign cond_eff = IS_UPPER ? (cond_raw & ~`PPSB_LOWER_ONLY_MASK) : cond_raw;  // [RULE_16]

  genvar gi;
  generate
    for (gi = 0; gi < `PPSB_OP_FLAG_COUNT; gi++) begin : g_flag
      ppsb_sticky_flag u_flag (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .cond     (cond_eff[gi]),
        .read_clr (op_read),  // [RULE_05] [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_10]
        .flag     (flags[gi])
      );
    end
  endgenerate

  always_comb begin
    cfg_value                      = 8'h00;  // [RULE_03]
    cfg_value[`PPSB_CFG_UPPER_BIT] = IS_UPPER;  // [RULE_01]
    cfg_value[`PPSB_CFG_LOWER_BIT] = ~IS_UPPER;  // [RULE_02]
    cfg_value[`PPSB_CFG_WAKE_BIT]  = wake_pin_status;  // [RULE_04]
  end

  always_comb begin
    st_next         = st_reg;
    st_next.fet_clr = force_sleep;  // [RULE_15]
    if (reg_rd) begin
      case (reg_addr)
        `PPSB_ADDR_CFG_STATUS:   st_next.rdata = cfg_value;
        `PPSB_ADDR_OP_STATUS:    st_next.rdata = {2'h0, flags};
        `PPSB_ADDR_CELL_BALANCE: st_next.rdata = st_reg.bal;
        default:                 st_next.rdata = 8'h00;
      endcase
    end
    // reserved bit 0 is forced to zero whatever software writes
    if (reg_wr && (reg_addr == `PPSB_ADDR_CELL_BALANCE)) begin
      st_next.bal = reg_wdata & `PPSB_BAL_WRITE_MASK;  // [RULE_11] [RULE_14]
    end
    // sleep wins over a write in the same cycle
    if (force_sleep) begin
      st_next.bal = `PPSB_BAL_RESET;  // [RULE_15]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata       = st_reg.rdata;
  assign fet_drive_clear = st_reg.fet_clr;
  assign balance_cell[6:1] = st_reg.bal[6:1];  // [RULE_11]
  // bit 7 still stores on the lower device but drives no switch there
  assign balance_cell[7] = st_reg.bal[`PPSB_BAL_CELL7_BIT] & IS_UPPER;  // [RULE_13]
  assign wake_request_output = st_reg.bal[`PPSB_BAL_WAKE_REQ_BIT] & ~IS_UPPER;  // [RULE_12]

  property p_cfg_upper;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `PPSB_ADDR_CFG_STATUS) |=> (reg_rdata[7] == IS_UPPER);
  endproperty
  a_cfg_upper: assert property (p_cfg_upper) else $error("upper flag wrong");  // [RULE_01]

  property p_cfg_lower;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `PPSB_ADDR_CFG_STATUS) |=> (reg_rdata[6] == !IS_UPPER);
  endproperty
  a_cfg_lower: assert property (p_cfg_lower) else $error("lower flag wrong");  // [RULE_02]

  property p_cfg_rsvd;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `PPSB_ADDR_CFG_STATUS) |=> (reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0);
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved config bits not zero");  // [RULE_03]

  property p_cfg_wake;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `PPSB_ADDR_CFG_STATUS)
      |=> (reg_rdata[4] == ($past(wake_pin_above) == $past(wake_polarity)));
  endproperty
  a_cfg_wake: assert property (p_cfg_wake) else $error("wake status wrong");  // [RULE_04]

  property p_keep_on_read;
    @(posedge core_clk) disable iff (!rst_b)
      op_read |=> ((flags & $past(cond_eff)) == $past(cond_eff));
  endproperty
  a_keep_on_read: assert property (p_keep_on_read) else $error("live flag cleared by read");  // [RULE_17]

  property p_coc_read;
    @(posedge core_clk) disable iff (!rst_b)
      (op_read && flags[`PPSB_OP_COC_BIT] && !charge_overcurrent)
      |=> (reg_rdata[`PPSB_OP_COC_BIT] && !flags[`PPSB_OP_COC_BIT]);
  endproperty
  a_coc_read: assert property (p_coc_read) else $error("charge overcurrent flag sequence wrong");  // [RULE_10]

  property p_bal_write;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `PPSB_ADDR_CELL_BALANCE && !force_sleep)
      |=> (balance_cell[6:1] == $past(reg_wdata[6:1]));
  endproperty
  a_bal_write: assert property (p_bal_write) else $error("balance outputs do not follow write");  // [RULE_11]

  property p_sleep;
    @(posedge core_clk) disable iff (!rst_b)
      force_sleep |=> (balance_cell == 7'h00 && !wake_request_output && fet_drive_clear);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not clear balance");  // [RULE_15]

  property p_wake_req;
    @(posedge core_clk) disable iff (!rst_b)
      wake_request_output |-> (!IS_UPPER && balance_cell[6]);
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("wake request on wrong device");  // [RULE_12]

  property p_cell7;
    @(posedge core_clk) disable iff (!rst_b)
      balance_cell[7] |-> IS_UPPER;
  endproperty
  a_cell7: assert property (p_cell7) else $error("cell 7 balance on lower device");  // [RULE_13]

  property p_upper_zero;
    @(posedge core_clk) disable iff (!rst_b)
      (IS_UPPER && op_read) |=> ((reg_rdata & 8'hEF) == 8'h00);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused status bits nonzero on upper");  // [RULE_16]

  property p_flag_snapshot;
    @(posedge core_clk) disable iff (!rst_b)
      op_read |=> (reg_rdata[5:0] == $past(flags) && reg_rdata[7:6] == 2'h0);
  endproperty
  a_flag_snapshot: assert property (p_flag_snapshot) else $error("op status read data wrong");  // [RULE_05]

  property p_ldf_needs_monitor;
    @(posedge core_clk) disable iff (!rst_b)
      (!load_monitor && !flags[`PPSB_OP_LDF_BIT]) |=> !flags[`PPSB_OP_LDF_BIT];
  endproperty
  a_ldf_needs_monitor: assert property (p_ldf_needs_monitor) else $error("load fail set while unmonitored");  // [RULE_07]

  property p_bal_rsvd;
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `PPSB_ADDR_CELL_BALANCE) |=> !reg_rdata[0];
  endproperty
  a_bal_rsvd: assert property (p_bal_rsvd) else $error("reserved balance bit nonzero");  // [RULE_11]

  // the clear request must drop once sleep is gone, or the switches could never come back
  property p_sleep_release;
    @(posedge core_clk) disable iff (!rst_b)
      !force_sleep |=> !fet_drive_clear;
  endproperty
  a_sleep_release: assert property (p_sleep_release) else $error("switch clear held without sleep");  // [RULE_15]

endmodule // ppsb_status_balance

// ===== tb/ppsb_host_model.sv
`timescale 1ns/1ns
module ppsb_host_model (
  // clock
  input  wire logic       core_clk,
  // read data of the lower and upper device
  input  wire logic [7:0] rdata_lo,
  input  wire logic [7:0] rdata_up,
  // register strobe port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // idle lines carry the inverse so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d & 8'hFE;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] lo, output logic [7:0] up);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    lo       = rdata_lo; // reserved bits are still compared by the bench
    up       = rdata_up;
  endtask
endmodule // ppsb_host_model

// ===== tb/ppsb_status_balance_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module ppsb_status_balance_tb;
  logic       core_clk, rst_b, reg_wr, reg_rd, wake_pin_above, wake_polarity, force_sleep;
  logic [7:0] reg_addr, reg_wdata;
  logic [6:0] cnd;
  logic [7:0] rdata [2];
  logic [7:1] bal [2];
  logic       fet [2];
  logic       wreq [2];
  int         miscompares, cmp_count, cycles;

  initial begin core_clk = 1'b0; forever #10 core_clk = ~core_clk; end

  // index 0 is the lower device, index 1 the upper
  for (genvar g = 0; g < 2; g++) begin : gen_dev
    ppsb_status_balance #(.IS_UPPER(g == 1)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata[g]),
      .wake_pin_above(wake_pin_above), .wake_polarity(wake_polarity), .ext_overtemp(cnd[6]),
      .int_overtemp(cnd[5]), .load_monitor(cnd[4]), .load_heavy(cnd[3]), .discharge_short(cnd[2]),
      .discharge_overcurrent(cnd[1]), .charge_overcurrent(cnd[0]), .force_sleep(force_sleep),
      .fet_drive_clear(fet[g]), .balance_cell(bal[g]), .wake_request_output(wreq[g]));
  end

  ppsb_host_model u_host (.core_clk(core_clk), .rdata_lo(rdata[0]), .rdata_up(rdata[1]),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] elo, input logic [7:0] eup);
    logic [7:0] lo, up;
    u_host.rd(a, lo, up);
    `CHK("rdata lower", elo, lo)
    `CHK("rdata upper", eup, up)
  endtask

  task automatic test_cfg();
    logic w;
    u_host.wr(8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      {wake_pin_above, wake_polarity} = i[1:0];
      w = i[1] == i[0];
      rd_chk(8'h00, {3'h2, w, 4'h0}, {3'h4, w, 4'h0});
    end
    $display("test cfg done");
  endtask

  task automatic test_flags();
    logic [6:0] st [8] = '{7'h40, 7'h20, 7'h1A, 7'h04, 7'h02, 7'h01, 7'h0A, 7'h16};
    logic [7:0] ex [8] = '{8'h20, 8'h10, 8'h0A, 8'h04, 8'h02, 8'h01, 8'h02, 8'h06};
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      cnd = st[i];
      rd_chk(8'h01, ex[i], ex[i] & 8'h10);
      rd_chk(8'h01, ex[i], ex[i] & 8'h10);
      @(negedge core_clk);
      cnd = 7'h00;
      rd_chk(8'h01, ex[i], ex[i] & 8'h10);
      rd_chk(8'h01, 8'h00, 8'h00);
    end
    $display("test flags done");
  endtask

  task automatic test_bal();
    logic [7:0] vals [4] = '{8'h7E, 8'h82, 8'h40, 8'hFF};
    foreach (vals[i]) begin
      u_host.wr(8'h02, vals[i]);
      `CHK("balance lower", {1'b0, vals[i][6:1]}, bal[0])
      `CHK("balance upper", vals[i][7:1], bal[1])
      `CHK("wake req lower", vals[i][6], wreq[0])
      `CHK("wake req upper", 1'b0, wreq[1])
      rd_chk(8'h02, vals[i] & 8'hFE, vals[i] & 8'hFE);
    end
    @(negedge core_clk);
    force_sleep = 1'b1;
    @(negedge core_clk);
    force_sleep = 1'b0;
    `CHK("fet clear lower", 1'b1, fet[0])
    `CHK("fet clear upper", 1'b1, fet[1])
    `CHK("balance after sleep", 7'h00, bal[0])
    `CHK("balance upper after sleep", 7'h00, bal[1])
    `CHK("wake req after sleep", 1'b0, wreq[0])
    @(negedge core_clk);
    `CHK("fet clear released", 1'b0, fet[0])
    force_sleep = 1'b1;
    u_host.wr(8'h02, 8'h7E);
    force_sleep = 1'b0;
    `CHK("balance write during sleep", 7'h00, bal[0])
    rd_chk(8'h02, 8'h00, 8'h00);
    rd_chk(8'h03, 8'h00, 8'h00);
    $display("test bal done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hung run is cut short well above the roughly 130 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    rst_b = 1'b0;
    {wake_pin_above, wake_polarity, force_sleep} = 3'h0;
    cnd = 7'h00;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    test_cfg();
    test_flags();
    test_bal();
    results();
  end
endmodule // ppsb_status_balance_tb
